/* File: ebwbe_pkg.sv */
// Purpose: Shared types and constants of the bus-cycle timing and bank expansion block
// Assumes: 20-bit CPU address, 22-bit expanded external address
// Notes:   Address map boundaries are plain defaults and may be moved per product
package ebwbe_pkg;

    localparam int          AW = 20;
    localparam int          XW = 22;

    // Bus cycle lengths in bus clock cycles
    localparam logic [2:0]  CYC_1 = 3'h1;
    localparam logic [2:0]  CYC_2 = 3'h2;
    localparam logic [2:0]  CYC_3 = 3'h3;
    localparam logic [2:0]  CYC_4 = 3'h4;

    // Wait count and space mode field encodings
    localparam logic [1:0]  WC_ONE   = 2'h0;
    localparam logic [1:0]  WC_TWO   = 2'h1;
    localparam logic [1:0]  SPACE_4M = 2'h3;

    // Address map
    localparam logic [19:0] SFR_LIMIT  = 20'h00400;
    localparam logic [19:0] IRAM_LIMIT = 20'h04000;
    localparam logic [19:0] CS3_LIMIT  = 20'h08000;
    localparam logic [19:0] CS2_LIMIT  = 20'h28000;
    localparam logic [19:0] CS1_LIM_1M = 20'h30000;
    localparam logic [19:0] CS1_LIM_4M = 20'h40000;
    localparam logic [19:0] BANK_BASE  = 20'h40000;
    localparam logic [19:0] BANK_LIMIT = 20'hc0000;
    localparam logic [19:0] IROM_BASE  = 20'hd0000;
    localparam logic [21:0] BANK_OFS   = 22'h040000;
    localparam int          BANK_SHIFT = 19;
    localparam int          HALF_BITS  = 18;

    localparam logic [3:0]  CS_IDLE = 4'hf;

    typedef enum logic [1:0] {RG_SFR, RG_INT, RG_EXT} ebwbe_region_t;
    typedef enum logic       {ST_IDLE, ST_STROBE} ebwbe_state_e_t;

    typedef struct packed {
        logic       internal_wait_bit;
        logic       sfr_cycle_select;
        logic [3:0] area_nowait_bits;
        logic [7:0] area_wait_count_reg;
        logic [3:0] area_mux_bits;
        logic [1:0] space_mode_field;
        logic       internal_area_extend_bit;
        logic [2:0] data_bank_select;
        logic       bank_offset_bit;
        logic       microproc_mode;
    } ebwbe_cfg_t;

    localparam ebwbe_cfg_t CFG_RESET = '{default: '0};

    typedef struct packed {
        ebwbe_cfg_t     cfg;
        ebwbe_state_e_t st;
        ebwbe_region_t  region;
        logic [2:0]     cnt;
        logic [2:0]     cycles;
        logic           rdy_en;
        logic           strobe;
        logic           done;
        logic [3:0]     cs_n;
        logic [21:0]    addr;
    } ebwbe_state_t;

endpackage

/* File: ebwbe_ctrl.sv */
// Purpose: Bus cycle length, chip select and bank address generation of the external bus
// Assumes: Inputs synchronous to MCLK_I; one access at a time, requested while idle
// Notes:   Config writes during an access do not disturb it, the cycle length is latched
`timescale 1ns/1ps
`default_nettype none

module ebwbe_ctrl (
    // Clock, reset, enable
    input  wire logic              MCLK_I,
    input  wire logic              RESETN_I,
    input  wire logic              CE_I,
    // Configuration
    input  wire logic              CFG_WR_I,
    input  wire ebwbe_pkg::ebwbe_cfg_t CFG_I,
    output var  ebwbe_pkg::ebwbe_cfg_t CFG_O,
    // Access request
    input  wire logic              REQ_I,
    input  wire logic [19:0]       ADDR_I,
    input  wire logic              WRITE_I,
    input  wire logic              RDY_N_I,
    // Bus cycle outputs
    output logic                   BUSY_O,
    output logic                   STROBE_O,
    output logic                   DONE_O,
    output logic [3:0]             CS_N_O,
    output logic [21:0]            EXT_ADDR_O,
    output logic [2:0]             CYCLES_O
);

    ebwbe_pkg::ebwbe_state_t s_r;
    ebwbe_pkg::ebwbe_state_t s_nxt;

    localparam ebwbe_pkg::ebwbe_state_t S_RESET = '{
        cfg:    ebwbe_pkg::CFG_RESET,
        st:     ebwbe_pkg::ST_IDLE,
        region: ebwbe_pkg::RG_SFR,
        cnt:    3'h0,
        cycles: 3'h0,
        rdy_en: 1'b0,
        strobe: 1'b0,
        done:   1'b0,
        cs_n:   ebwbe_pkg::CS_IDLE,
        addr:   22'h000000
    };

    always_comb begin
        logic                     is_4m;
        logic                     in_bank;
        logic                     halves;
        logic [1:0]               idx;
        logic [1:0]               wc;
        logic                     nw;
        logic [2:0]               need;
        logic [3:0]               cs_val;
        logic [18:0]              win;
        logic [21:0]              phys;
        ebwbe_pkg::ebwbe_region_t rg;
        is_4m   = (s_r.cfg.space_mode_field == ebwbe_pkg::SPACE_4M);
        in_bank = is_4m && (ADDR_I >= ebwbe_pkg::BANK_BASE)
                        && (ADDR_I < ebwbe_pkg::BANK_LIMIT);
        halves  = !s_r.cfg.microproc_mode && s_r.cfg.internal_area_extend_bit;
        idx     = 2'h0;
        rg      = ebwbe_pkg::RG_EXT;
        win     = 19'(ADDR_I - ebwbe_pkg::BANK_BASE);
        phys    = {2'h0, ADDR_I};
        cs_val  = ebwbe_pkg::CS_IDLE;
        nw      = 1'b0;
        wc      = ebwbe_pkg::WC_ONE;
        need    = ebwbe_pkg::CYC_1;
        // Region decode; internal areas keep every select high
        if (ADDR_I < ebwbe_pkg::SFR_LIMIT) begin
            rg = ebwbe_pkg::RG_SFR;
        end else if (ADDR_I < ebwbe_pkg::IRAM_LIMIT || ADDR_I >= ebwbe_pkg::IROM_BASE) begin
            rg = ebwbe_pkg::RG_INT;
        end else if (ADDR_I < ebwbe_pkg::CS3_LIMIT) begin
            idx = 2'h3;
        end else if (ADDR_I < ebwbe_pkg::CS2_LIMIT) begin
            idx = 2'h2;
        end else if (ADDR_I < (is_4m ? ebwbe_pkg::CS1_LIM_4M : ebwbe_pkg::CS1_LIM_1M)) begin
            idx = 2'h1;
        end
        if (rg == ebwbe_pkg::RG_EXT) begin
            if (in_bank) begin
                cs_val = {s_r.cfg.data_bank_select, 1'b0};
                if (halves) begin
                    phys = {s_r.cfg.data_bank_select, s_r.cfg.bank_offset_bit,
                            win[ebwbe_pkg::HALF_BITS-1:0]};
                end else begin
                    // A 512-Kbyte stride lets the offset step over a bank edge
                    phys = 22'({s_r.cfg.data_bank_select, 19'h00000}) + 22'(win)
                         + (s_r.cfg.bank_offset_bit ? ebwbe_pkg::BANK_OFS : 22'h000000);
                end
            end else begin
                cs_val = ~(4'h1 << idx);
            end
        end
        nw = s_r.cfg.area_nowait_bits[idx];
        wc = s_r.cfg.area_wait_count_reg[2*idx +: 2];
        case (rg)
            ebwbe_pkg::RG_SFR: begin
                need = s_r.cfg.sfr_cycle_select ? ebwbe_pkg::CYC_2 : ebwbe_pkg::CYC_3;
            end
            ebwbe_pkg::RG_INT: begin
                need = s_r.cfg.internal_wait_bit ? ebwbe_pkg::CYC_2 : ebwbe_pkg::CYC_1;
            end
            default: begin
                if (s_r.cfg.area_mux_bits[idx]) begin
                    // No-wait bit is ignored here; software must keep it clear
                    if (wc == ebwbe_pkg::WC_ONE || wc == ebwbe_pkg::WC_TWO) begin
                        need = ebwbe_pkg::CYC_3;
                    end else begin
                        need = ebwbe_pkg::CYC_4;
                    end
                end else if (nw) begin
                    need = WRITE_I ? ebwbe_pkg::CYC_2 : ebwbe_pkg::CYC_1;
                end else begin
                    case (wc)
                        ebwbe_pkg::WC_ONE: need = ebwbe_pkg::CYC_2;
                        ebwbe_pkg::WC_TWO: need = ebwbe_pkg::CYC_3;
                        default:           need = ebwbe_pkg::CYC_4;
                    endcase
                end
            end
        endcase

        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (CFG_WR_I) begin
            s_nxt.cfg = CFG_I;
        end
        case (s_r.st)
            ebwbe_pkg::ST_IDLE: begin
                if (REQ_I) begin
                    s_nxt.st     = ebwbe_pkg::ST_STROBE;
                    s_nxt.region = rg;
                    s_nxt.cycles = need;
                    s_nxt.cnt    = need;
                    s_nxt.rdy_en = (rg == ebwbe_pkg::RG_EXT) && !nw;
                    s_nxt.strobe = 1'b1;
                    s_nxt.cs_n   = cs_val;
                    s_nxt.addr   = phys;
                end
            end
            ebwbe_pkg::ST_STROBE: begin
                if (s_r.cnt > ebwbe_pkg::CYC_1) begin
                    s_nxt.cnt = s_r.cnt - ebwbe_pkg::CYC_1;
                end else if (!(s_r.rdy_en && RDY_N_I)) begin
                    s_nxt.st     = ebwbe_pkg::ST_IDLE;
                    s_nxt.strobe = 1'b0;
                    s_nxt.done   = 1'b1;
                    s_nxt.cs_n   = ebwbe_pkg::CS_IDLE;
                end
            end
            default: begin
                s_nxt = S_RESET;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_r <= S_RESET;
        end else if (CE_I) begin
            s_r <= s_nxt;
        end
    end

    assign CFG_O      = s_r.cfg;
    assign BUSY_O     = (s_r.st == ebwbe_pkg::ST_STROBE);
    assign STROBE_O   = s_r.strobe;
    assign DONE_O     = s_r.done;
    assign CS_N_O     = s_r.cs_n;
    assign EXT_ADDR_O = s_r.addr;
    assign CYCLES_O   = s_r.cycles;

    // Checking helpers
    logic       acc;
    logic [3:0] len_q;
    assign acc = REQ_I && (s_r.st == ebwbe_pkg::ST_IDLE);

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            len_q <= 4'h0;
        end else if (CE_I) begin
            len_q <= s_r.strobe ? len_q + 4'h1 : 4'h0;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I || !CE_I);

    sequence accept_ext_s;
        acc && ADDR_I >= ebwbe_pkg::CS3_LIMIT && ADDR_I < ebwbe_pkg::IROM_BASE;
    endsequence

    sequence start_s;
        $rose(s_r.strobe);
    endsequence

    sfr_cycles_a: assert property (
        start_s and (s_r.region == ebwbe_pkg::RG_SFR)
        |-> s_r.cycles == ($past(s_r.cfg.sfr_cycle_select) ? 3'h2 : 3'h3))
        else $error("register region cycle length wrong");

    int_cycles_a: assert property (
        start_s and (s_r.region == ebwbe_pkg::RG_INT)
        |-> s_r.cycles == ($past(s_r.cfg.internal_wait_bit) ? 3'h2 : 3'h1))
        else $error("internal memory cycle length wrong");

    nowait_cycles_a: assert property (
        accept_ext_s and !CFG_O.area_mux_bits[0] and CFG_O.area_nowait_bits[0]
        and ADDR_I >= ebwbe_pkg::CS1_LIM_4M and ADDR_I < ebwbe_pkg::BANK_LIMIT
        |=> CYCLES_O == ($past(WRITE_I) ? 3'h2 : 3'h1))
        else $error("no-wait area cycle length wrong");

    sep_wait_a: assert property (
        accept_ext_s and CFG_O.area_mux_bits == 4'h0 and CFG_O.area_nowait_bits == 4'h0
        and CFG_O.area_wait_count_reg == 8'h00
        |=> CYCLES_O == 3'h2)
        else $error("separate bus one-wait length wrong");

    mux_wait_a: assert property (
        accept_ext_s and CFG_O.area_mux_bits == 4'hf and CFG_O.area_wait_count_reg == 8'haa
        |=> CYCLES_O == 3'h4)
        else $error("multiplexed bus three-wait length wrong");

    strobe_len_a: assert property (
        acc |=> s_r.strobe and (s_r.rdy_en or ##[1:4] $fell(s_r.strobe)))
        else $error("strobe ended wrongly");

    strobe_count_a: assert property (
        $fell(s_r.strobe) && !$past(s_r.rdy_en) |-> len_q == {1'b0, $past(s_r.cycles)}
        && DONE_O)
        else $error("strobe length differs from latched count");

    bank_cs_a: assert property (
        acc and CFG_O.space_mode_field == ebwbe_pkg::SPACE_4M
        and ADDR_I >= ebwbe_pkg::BANK_BASE and ADDR_I < ebwbe_pkg::BANK_LIMIT
        |=> CS_N_O == {$past(CFG_O.data_bank_select), 1'b0} ##1 STROBE_O || DONE_O)
        else $error("bank window select lines wrong");

    one_mb_cs_a: assert property (
        accept_ext_s and CFG_O.space_mode_field == 2'h0 |=> $onehot(~CS_N_O))
        else $error("1-Mbyte space must assert one select");

    offset_a: assert property (
        acc and CFG_O.space_mode_field == ebwbe_pkg::SPACE_4M and CFG_O.bank_offset_bit
        and !CFG_O.internal_area_extend_bit and ADDR_I == ebwbe_pkg::BANK_BASE
        |=> EXT_ADDR_O == 22'({$past(CFG_O.data_bank_select), 19'h00000}) + 22'h040000)
        else $error("bank offset not applied");

    mux_area1_a: assert property (
        acc and ADDR_I >= ebwbe_pkg::CS2_LIMIT and ADDR_I < ebwbe_pkg::CS1_LIM_1M
        and CFG_O.area_mux_bits[1] and !CFG_O.area_wait_count_reg[3]
        |=> CYCLES_O == 3'h3)
        else $error("multiplexed bus short length wrong");

    half_bank_a: assert property (
        acc and CFG_O.space_mode_field == ebwbe_pkg::SPACE_4M
        and CFG_O.internal_area_extend_bit and !CFG_O.microproc_mode
        and ADDR_I >= ebwbe_pkg::BANK_BASE and ADDR_I < ebwbe_pkg::BANK_LIMIT
        |=> EXT_ADDR_O == {$past(CFG_O.data_bank_select), $past(CFG_O.bank_offset_bit),
                           $past(ADDR_I[ebwbe_pkg::HALF_BITS-1:0])})
        else $error("bank half address wrong");

    idle_cs_a: assert property (
        !BUSY_O |-> CS_N_O == ebwbe_pkg::CS_IDLE)
        else $error("select active while idle");

    done_pulse_a: assert property (
        DONE_O |=> !DONE_O)
        else $error("done longer than one cycle");

    addr_hold_a: assert property (
        BUSY_O && $past(BUSY_O) |-> $stable(EXT_ADDR_O) && $stable(CS_N_O))
        else $error("address or select moved in access");

    reset_cfg_a: assert property (
        @(posedge MCLK_I) disable iff (1'b0)
        !RESETN_I |-> CFG_O.internal_wait_bit == 1'b0 && CFG_O.area_nowait_bits == 4'h0
        && CFG_O.area_wait_count_reg == 8'h00 && !STROBE_O)
        else $error("reset defaults wrong");

endmodule

`default_nettype wire

/* File: ebwbe_mem_model.sv */
// Purpose: External memory on the far side of the bus, answering ready promptly or late
// Assumes: Ready is active low and sampled by the controller in the last strobe cycle
// Notes:   Ready reads as not ready outside selected strobes so a stray sample shows
`timescale 1ns/1ps
`default_nettype none

module ebwbe_mem_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Bus side
    input  wire logic       strobe_i,
    input  wire logic [3:0] cs_n_i,
    input  wire logic [2:0] stall_i,
    output logic            rdy_n_o
);
    logic [2:0] cnt_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 3'h0;
        end else if (!strobe_i) begin
            cnt_r <= 3'h0;
        end else if (cnt_r != 3'h7) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // Held not ready for the first stall_i strobe cycles of a selected access
    assign rdy_n_o = !(strobe_i && cs_n_i != 4'hf) || (cnt_r < stall_i);
endmodule

`default_nettype wire

/* File: ebwbe_ctrl_tb_top.sv */
// Purpose: Self-checking bench for bus cycle length, chip selects and bank addresses
// Assumes: One access at a time; clock enable dropped in one scenario only
// Notes:   Strobe length is counted at the falling edge, away from the launching edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module ebwbe_ctrl_tb_top;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b1;
    logic                 ce = 1'b1;
    logic                 cfg_wr = 1'b0;
    logic                 req = 1'b0;
    logic                 wr = 1'b0;
    logic [19:0]          addr = 20'h0;
    logic [2:0]           stall = 3'h0;
    ebwbe_pkg::ebwbe_cfg_t cfg = '0;
    ebwbe_pkg::ebwbe_cfg_t cfg_in = '0;
    ebwbe_pkg::ebwbe_cfg_t cfg_o;
    logic                 rdy_n, busy, strobe, done;
    logic [3:0]           cs_n;
    logic [21:0]          ext_addr;
    logic [2:0]           cycles;
    int                   n_fail = 0;
    int                   comparisons = 0;

    ebwbe_ctrl i_ebwbe_ctrl (.MCLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .CFG_WR_I(cfg_wr),
        .CFG_I(cfg_in), .CFG_O(cfg_o), .REQ_I(req), .ADDR_I(addr), .WRITE_I(wr),
        .RDY_N_I(rdy_n), .BUSY_O(busy), .STROBE_O(strobe), .DONE_O(done), .CS_N_O(cs_n),
        .EXT_ADDR_O(ext_addr), .CYCLES_O(cycles));

    ebwbe_mem_model i_ebwbe_mem_model (.clk_i(clk), .rst_n_i(rst_n), .strobe_i(strobe),
        .cs_n_i(cs_n), .stall_i(stall), .rdy_n_o(rdy_n));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic wr_cfg;
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_in <= cfg;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask

    task automatic acc(input logic [19:0] a, input logic w, input logic [2:0] n,
                       input logic [3:0] cs, input logic [21:0] xa);
        int s;
        int es;
        logic [3:0] cs_seen;
        logic       b_seen;
        s = 0;
        cs_seen = 4'h0;
        b_seen = 1'b0;
        es = (int'(stall) + 1 > int'(n)) ? int'(stall) + 1 : int'(n);
        @(posedge clk);
        req <= 1'b1;
        addr <= a;
        wr <= w;
        @(posedge clk);
        req <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            if (done === 1'b1) break;
            if (strobe === 1'b1) begin
                if (s == 0) begin
                    cs_seen = cs_n;
                    b_seen = busy;
                end
                s++;
            end
        end
        `CHK("strobe_len", es, s)
        `CHK("cycles", n, cycles)
        `CHK("cs_n", cs, cs_seen)
        `CHK("ext_addr", xa, ext_addr)
        `CHK("busy", 1'b1, b_seen)
        `CHK("done", 1'b1, done)
        `CHK("busy_end", 1'b0, busy)
    endtask

    task automatic t_reset;
        `CHK("cfg_reset", ebwbe_pkg::CFG_RESET, cfg_o)
        acc(20'h30000, 1'b0, 3'h2, 4'he, 22'h030000);
    endtask

    task automatic t_sfr_int;
        cfg = ebwbe_pkg::CFG_RESET;
        cfg.area_wait_count_reg = 8'haa;
        for (int i = 0; i < 2; i++) begin
            cfg.sfr_cycle_select = i[0];
            cfg.internal_wait_bit = i[0];
            wr_cfg();
            acc(20'h00100, 1'b0, i ? 3'h2 : 3'h3, 4'hf, 22'h000100);
            acc(20'h00400, 1'b1, i ? 3'h2 : 3'h1, 4'hf, 22'h000400);
            acc(20'hd0000, 1'b0, i ? 3'h2 : 3'h1, 4'hf, 22'h0d0000);
        end
    endtask

    task automatic t_sep;
        cfg = ebwbe_pkg::CFG_RESET;
        cfg.area_nowait_bits = 4'h9;
        wr_cfg();
        acc(20'h04000, 1'b0, 3'h1, 4'h7, 22'h004000);
        acc(20'h04000, 1'b1, 3'h2, 4'h7, 22'h004000);
        acc(20'h40000, 1'b0, 3'h1, 4'he, 22'h040000);
        acc(20'h40000, 1'b1, 3'h2, 4'he, 22'h040000);
        cfg.area_nowait_bits = 4'h0;
        for (int i = 0; i < 3; i++) begin
            cfg.area_wait_count_reg[5:4] = i[1:0];
            wr_cfg();
            acc(20'h08000, 1'b0, 3'(i + 2), 4'hb, 22'h008000);
        end
        cfg.area_wait_count_reg = 8'h0;
        cfg.internal_wait_bit = 1'b1;
        wr_cfg();
        acc(20'h08000, 1'b1, 3'h2, 4'hb, 22'h008000);
    endtask

    task automatic t_mux;
        cfg = ebwbe_pkg::CFG_RESET;
        cfg.area_mux_bits = 4'h2;
        for (int i = 0; i < 3; i++) begin
            cfg.area_wait_count_reg[3:2] = i[1:0];
            wr_cfg();
            acc(20'h28000, 1'b1, i == 2 ? 3'h4 : 3'h3, 4'hd, 22'h028000);
        end
        cfg.area_wait_count_reg = 8'h0;
        cfg.internal_wait_bit = 1'b1;
        wr_cfg();
        acc(20'h28000, 1'b0, 3'h3, 4'hd, 22'h028000);
        cfg.area_mux_bits = 4'hf;
        cfg.area_wait_count_reg = 8'haa;
        wr_cfg();
        acc(20'h28000, 1'b0, 3'h4, 4'hd, 22'h028000);
    endtask

    task automatic t_rdy;
        cfg = ebwbe_pkg::CFG_RESET;
        wr_cfg();
        stall = 3'h4;
        acc(20'h30000, 1'b0, 3'h2, 4'he, 22'h030000);
        stall = 3'h0;
    endtask

    task automatic t_4m;
        cfg = ebwbe_pkg::CFG_RESET;
        cfg.space_mode_field = 2'h3;
        cfg.data_bank_select = 3'h5;
        wr_cfg();
        acc(20'h40000, 1'b0, 3'h2, 4'ha, 22'h280000);
        cfg.bank_offset_bit = 1'b1;
        wr_cfg();
        acc(20'h80010, 1'b0, 3'h2, 4'ha, 22'h300010);
        acc(20'h40000, 1'b0, 3'h2, 4'ha, 22'h2c0000);
        acc(20'h30000, 1'b0, 3'h2, 4'hd, 22'h030000);
        acc(20'hc0000, 1'b0, 3'h2, 4'he, 22'h0c0000);
        cfg.internal_area_extend_bit = 1'b1;
        wr_cfg();
        acc(20'h80010, 1'b1, 3'h2, 4'ha, 22'h2c0010);
        cfg.space_mode_field = 2'h0;
        wr_cfg();
        acc(20'h40000, 1'b0, 3'h2, 4'he, 22'h040000);
    endtask

    // Enable low for three edges in mid strobe must stretch it by three cycles
    task automatic t_ce;
        @(posedge clk);
        req <= 1'b1;
        addr <= 20'h30000;
        wr <= 1'b0;
        @(posedge clk);
        req <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        `CHK("ce_freeze", 1'b1, strobe)
        repeat (2) @(negedge clk);
        `CHK("ce_done", 1'b1, done)
    endtask

    initial begin
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_sfr_int();
        t_sep();
        t_mux();
        t_rdy();
        t_4m();
        t_ce();
        report_and_stop();
    end

    // About 30 accesses of under 20 cycles each
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule

`default_nettype wire
